// [design/reset_strap_clock_ratio.sv]
// strap sampling, ratio latch, pin control and register slave
`include "strap_consts.svh"
`default_nettype none
module reset_strap_clock_ratio
    import strap_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // power-on reset from the pin
    input wire logic por_n_pin,
    // strap pins
    input wire logic [3:0] platform_ratio_straps,
    input wire logic core_ratio_strap_buscontrol,
    input wire logic core_ratio_strap_addrlatch,
    input wire logic core_ratio_strap_gpline,
    input wire logic boot_flash_strap,
    input wire logic pci_arbiter_strap,
    input wire logic [1:0] dma_acknowledge_strap,
    input wire logic [3:0] cfg_spare_straps,
    // strap pad pull-up control
    output logic strap_pullup_en,
    // decoded clocking
    output logic [4:0] platform_mult,
    output logic [3:0] core_ratio_half,
    output logic ratio_valid,
    output logic memory_clock_div2,
    output logic boot_from_flash,
    // pci address pad control
    input wire logic [31:0] pci_addr_core,
    input wire logic pci_addr_core_oe,
    output logic [31:0] pci_addr_out,
    output logic pci_addr_oe,
    // ethernet flow control pad
    input wire logic eth_flow_ctrl_core,
    output logic eth_flow_out,
    output logic eth_flow_oe,
    // reset-driven status pins
    input wire logic reset_request_core,
    output logic reset_request_out,
    output logic trigger_ready_out,
    // axi4-lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // por plus 4+3+1+1+2+4 straps = 16 bits
    localparam int SW = 16;
    logic [SW-1:0] raw;
    logic [SW-1:0] s1_r, s2_r, s3_r, s1_nxt, s2_nxt, s3_nxt;
    logic [SW-1:0] stab_r, stab_nxt;
    assign raw = {por_n_pin, platform_ratio_straps, core_ratio_strap_buscontrol,
                  core_ratio_strap_addrlatch, core_ratio_strap_gpline, boot_flash_strap,
                  pci_arbiter_strap, dma_acknowledge_strap, cfg_spare_straps};
    always_comb begin
        s1_nxt = raw;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        stab_nxt = stab_r;
        for (int i = 0; i < SW; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                stab_nxt[i] = s3_r[i];
            end
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            stab_r <= '0;
        end else if (clk_en) begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            stab_r <= stab_nxt;
        end
    end
    logic por_active;
    logic [3:0] st_plat;
    logic [2:0] st_core;
    logic st_boot, st_arb;
    assign por_active = ~stab_r[15];
    assign st_plat = stab_r[14:11];
    // order: bus control, address latch, gp line
    assign st_core = stab_r[10:8];
    assign st_boot = stab_r[7];
    assign st_arb = stab_r[6];

    // ----------------------------------------
    // decode
    // ----------------------------------------
    mult_t dec_plat;
    logic dec_plat_bad, dec_core_bad;
    logic [3:0] dec_core;
    strap_decoder u_dec (
        .plat_code(st_plat),
        .core_code(st_core),
        .plat_mult(dec_plat),
        .plat_reserved(dec_plat_bad),
        .core_half(dec_core),
        .core_reserved(dec_core_bad)
    );

    // ----------------------------------------
    // reset phase and ratio latch
    // ----------------------------------------
    phase_t phase_r, phase_nxt;
    mult_t plat_r, plat_nxt;
    logic [3:0] core_r, core_nxt;
    logic plat_bad_r, plat_bad_nxt, core_bad_r, core_bad_nxt;
    logic boot_r, boot_nxt, arb_r, arb_nxt;
    logic [3:0] strap_img_r, strap_img_nxt;
    always_comb begin
        phase_nxt = phase_r;
        plat_nxt = plat_r;
        core_nxt = core_r;
        plat_bad_nxt = plat_bad_r;
        core_bad_nxt = core_bad_r;
        boot_nxt = boot_r;
        arb_nxt = arb_r;
        strap_img_nxt = strap_img_r;
        case (phase_r)
            PH_RESET: begin
                if (!por_active) begin
                    phase_nxt = PH_LATCH;
                end
            end
            PH_LATCH: begin
                // straps still stable from reset; take them once
                plat_nxt = dec_plat;
                core_nxt = dec_core;
                plat_bad_nxt = dec_plat_bad;
                core_bad_nxt = dec_core_bad;
                boot_nxt = st_boot;
                arb_nxt = st_arb;
                strap_img_nxt = stab_r[3:0];
                phase_nxt = PH_RUN;
            end
            PH_RUN: begin
                // held until the next power-on reset
                if (por_active) begin
                    phase_nxt = PH_RESET;
                end
            end
            default: phase_nxt = PH_RESET;
        endcase
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= PH_RESET;
            plat_r <= '0;
            core_r <= '0;
            plat_bad_r <= 1'b0;
            core_bad_r <= 1'b0;
            boot_r <= 1'b0;
            arb_r <= 1'b0;
            strap_img_r <= '0;
        end else if (clk_en) begin
            phase_r <= phase_nxt;
            plat_r <= plat_nxt;
            core_r <= core_nxt;
            plat_bad_r <= plat_bad_nxt;
            core_bad_r <= core_bad_nxt;
            boot_r <= boot_nxt;
            arb_r <= arb_nxt;
            strap_img_r <= strap_img_nxt;
        end
    end
    logic running;
    assign running = (phase_r == PH_RUN);

    // ----------------------------------------
    // register file and axi4-lite slave
    // ----------------------------------------
    logic [31:0] ctrl_r, ctrl_nxt;
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt, bvalid_r, bvalid_nxt;
    logic [11:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] ratio_word, strap_word;
    assign ratio_word = {13'h0000, running & ~plat_bad_r & ~core_bad_r, core_bad_r, plat_bad_r,
                         4'h0, core_r, 3'h0, plat_r};
    assign strap_word = {16'h0000, stab_r[15:0]};
    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready = ~w_held_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        ctrl_nxt = ctrl_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (aw_held_r && w_held_r) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = `AXI_OKAY;
            case (awaddr_r[11:2])
                10'(`OFS_CONTROL >> 2): begin
                    for (int b = 0; b < 4; b++) begin
                        if (wstrb_r[b]) begin
                            ctrl_nxt[b*8 +: 8] = wdata_r[b*8 +: 8];
                        end
                    end
                    ctrl_nxt[31:2] = '0;
                end
                10'(`OFS_RATIO >> 2), 10'(`OFS_STRAPS >> 2): bresp_nxt = `AXI_OKAY;
                default: bresp_nxt = `AXI_DECERR;
            endcase
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `AXI_OKAY;
            case (s_axi_araddr[11:2])
                10'(`OFS_RATIO >> 2): rdata_nxt = ratio_word;
                10'(`OFS_STRAPS >> 2): rdata_nxt = strap_word;
                10'(`OFS_CONTROL >> 2): rdata_nxt = ctrl_r;
                default: begin
                    rdata_nxt = '0;
                    rresp_nxt = `AXI_DECERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= `AXI_OKAY;
            ctrl_r <= `CONTROL_RESET;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `AXI_OKAY;
        end else if (clk_en) begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            ctrl_r <= ctrl_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ----------------------------------------
    // pad and clocking outputs
    // ----------------------------------------
    logic pci_disabled, fifo_mode;
    assign pci_disabled = ctrl_r[`CTRL_DEVDIS_BIT];
    assign fifo_mode = ctrl_r[`CTRL_FIFO_BIT];
    assign strap_pullup_en = ~running;
    assign platform_mult = plat_r;
    assign core_ratio_half = core_r;
    assign ratio_valid = ratio_word[`RATIO_VALID_BIT];
    assign memory_clock_div2 = running;
    assign boot_from_flash = boot_r;
    // arbiter keeps address pins driven even when disabled
    assign pci_addr_oe = running & (arb_r | (pci_addr_core_oe & ~pci_disabled));
    assign pci_addr_out = pci_addr_core;
    assign eth_flow_out = eth_flow_ctrl_core;
    assign eth_flow_oe = running & fifo_mode;
    // driven low during reset, never left floating
    assign reset_request_out = running ? reset_request_core : 1'b0;
    assign trigger_ready_out = running;
    logic unused;
    assign unused = ^{strap_img_r, pci_addr_core_oe};
endmodule : reset_strap_clock_ratio
`default_nettype wire

// [design/strap_consts.svh]
// constants and behaviour notes for the reset strap and clock ratio block
// Notes on behaviour
// - sample four platform straps during power-on reset
// - decode platform strap into multiplier, others reserved
// - decode three core straps into core ratio
// - memory bus clock is half platform clock; memory_clock_div2 is set only in the run phase, low in reset and latch
// - arbiter strap forces PCI address drive whenever running
// - chosen outputs stay driven throughout reset
// - ethernet flow pin outputs only in FIFO mode
// - weak pull-up enabled in the reset and latch phases, off only in the run phase
`ifndef STRAP_CONSTS_SVH
`define STRAP_CONSTS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_RATIO 12'h000
`define OFS_STRAPS 12'h004
`define OFS_CONTROL 12'h008
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define RATIO_PLAT_LSB 0
`define RATIO_CORE_LSB 8
`define RATIO_PLAT_BAD_BIT 16
`define RATIO_CORE_BAD_BIT 17
`define RATIO_VALID_BIT 18
`define CTRL_DEVDIS_BIT 0
`define CTRL_FIFO_BIT 1
`define CONTROL_RESET 32'h00000000
`define AXI_OKAY 2'h0
`define AXI_DECERR 2'h3
`endif

// [design/strap_decoder.sv]
// combinational decode of platform and core ratio straps
`include "strap_consts.svh"
`default_nettype none
module strap_decoder
    import strap_pkg::*;
(
    // straps
    input wire logic [3:0] plat_code,
    input wire logic [2:0] core_code,
    // decoded ratios
    output mult_t plat_mult,
    output logic plat_reserved,
    output logic [3:0] core_half,
    output logic core_reserved
);
    always_comb begin
        plat_reserved = 1'b0;
        case (plat_code)
            4'h0: plat_mult = 5'h10;
            4'h3: plat_mult = 5'h03;
            4'h4: plat_mult = 5'h04;
            4'h5: plat_mult = 5'h05;
            4'h6: plat_mult = 5'h06;
            4'h8: plat_mult = 5'h08;
            4'h9: plat_mult = 5'h09;
            4'hA: plat_mult = 5'h0A;
            4'hC: plat_mult = 5'h0C;
            default: begin
                plat_mult = 5'h00; // no default multiplier
                plat_reserved = 1'b1;
            end
        endcase
    end
    // core ratio in half steps: 4:1 -> 8, 3:2 -> 3
    always_comb begin
        core_reserved = 1'b0;
        case (core_code)
            3'h0: core_half = 4'h8;
            3'h3: core_half = 4'h3;
            3'h4: core_half = 4'h4;
            3'h5: core_half = 4'h5;
            3'h6: core_half = 4'h6;
            3'h7: core_half = 4'h7;
            default: begin
                core_half = 4'h0;
                core_reserved = 1'b1;
            end
        endcase
    end
endmodule : strap_decoder
`default_nettype wire

// [design/strap_pkg.sv]
// types for the reset strap and clock ratio block
`default_nettype none
package strap_pkg;
    typedef enum logic [1:0] {
        PH_RESET = 2'b00,
        PH_LATCH = 2'b01,
        PH_RUN = 2'b10
    } phase_t;
    typedef logic [4:0] mult_t;
endpackage : strap_pkg
`default_nettype wire

// [tb/ratio_ref.svh]
// reference decode of the platform and core ratio strap codes
function automatic logic [4:0] plat_ref(input logic [3:0] c);
    if (c == 4'h0) return 5'h10;
    return (c inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC}) ? {1'b0, c} : 5'h00;
endfunction : plat_ref
function automatic logic [3:0] core_ref(input logic [2:0] c);
    if (c == 3'h0) return 4'h8;
    return (c inside {3'h1, 3'h2}) ? 4'h0 : {1'b0, c};
endfunction : core_ref

// [tb/reset_strap_clock_ratio_tb.sv]
// self-checking bench for the strap and clock ratio block
`default_nettype none
module reset_strap_clock_ratio_tb;
    timeunit 1ns;
    timeprecision 1ps;
    `include "ratio_ref.svh"
    logic clk_sys, reset_n, clk_en, por_n_pin, arb_internal, pci_addr_core_oe;
    logic eth_flow_ctrl_core, reset_request_core, strap_pullup_en, ratio_valid;
    logic memory_clock_div2, boot_from_flash, pci_addr_oe, eth_flow_out, eth_flow_oe;
    logic reset_request_out, trigger_ready_out, core_ratio_strap_buscontrol;
    logic core_ratio_strap_addrlatch, core_ratio_strap_gpline, boot_flash_strap;
    logic pci_arbiter_strap;
    logic [3:0] plat_code, platform_ratio_straps, cfg_spare_straps, core_ratio_half, s_axi_wstrb;
    logic [2:0] core_code;
    logic [1:0] dma_acknowledge_strap, s_axi_bresp, s_axi_rresp;
    logic [4:0] platform_mult;
    logic [31:0] pci_addr_core, pci_addr_out, s_axi_wdata, s_axi_rdata;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int fail_count = 0;
    int cmp_count = 0;
    strap_board board (.plat_code, .core_code, .arb_internal, .platform_ratio_straps,
        .core_ratio_strap_buscontrol, .core_ratio_strap_addrlatch, .core_ratio_strap_gpline,
        .boot_flash_strap, .pci_arbiter_strap, .dma_acknowledge_strap, .cfg_spare_straps);
    reset_strap_clock_ratio dut (.*);
    always #12.5 clk_sys = ~clk_sys;
    // ----
    // tasks
    // ----
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    task axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : axi_write
    task axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        check("rdata", ed, s_axi_rdata);
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : axi_read
    function automatic logic [31:0] ratio_word(input logic [3:0] p, input logic [2:0] c);
        logic [4:0] m;
        logic [3:0] h;
        m = plat_ref(p);
        h = core_ref(c);
        return {13'h0, m != 5'h00 && h != 4'h0, h == 4'h0, m == 5'h00, 4'h0, h, 3'h0, m};
    endfunction : ratio_word
    // straps are set while por is low and left alone until run is seen
    task power_up(input logic [3:0] p, input logic [2:0] c);
        int n;
        logic [31:0] w;
        w = ratio_word(p, c);
        por_n_pin <= 1'b0;
        plat_code <= p;
        core_code <= c;
        repeat (6) @(posedge clk_sys);
        check("pullup in por", 32'h1, {31'h0, strap_pullup_en});
        check("status in por", 32'h0, {30'h0, trigger_ready_out, reset_request_out});
        por_n_pin <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!memory_clock_div2 && n < 20);
        check("platform mult", {27'h0, plat_ref(p)}, {27'h0, platform_mult});
        check("core half", {28'h0, core_ref(c)}, {28'h0, core_ratio_half});
        check("ratio valid", {31'h0, w[18]}, {31'h0, ratio_valid});
        check("pullup in run", 32'h0, {31'h0, strap_pullup_en});
        check("mem div2", 32'h1, {31'h0, memory_clock_div2});
        check("boot flash", 32'h1, {31'h0, boot_from_flash});
        check("status in run", 32'h3, {30'h0, trigger_ready_out, reset_request_out});
        axi_read(12'h000, w, 2'h0);
        plat_code <= ~p;
        core_code <= ~c;
        repeat (4) @(posedge clk_sys);
        check("mult held", {27'h0, plat_ref(p)}, {27'h0, platform_mult});
        check("core held", {28'h0, core_ref(c)}, {28'h0, core_ratio_half});
    endtask : power_up
    // ----
    // sequence
    // ----
    initial begin
        {clk_sys, reset_n, por_n_pin, pci_addr_core_oe, eth_flow_ctrl_core} = '0;
        {clk_en, arb_internal, reset_request_core} = 3'h7;
        {plat_code, core_code, pci_addr_core, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 16; i++) power_up(4'(i), 3'(i));
        power_up(4'h5, 3'h3);
        axi_read(12'h004, 32'h0000D4D0, 2'h0);
        axi_write(12'h008, 32'h2, 2'h0);
        axi_read(12'h008, 32'h2, 2'h0);
        eth_flow_ctrl_core <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check("flow oe fifo", 32'h3, {30'h0, eth_flow_oe, eth_flow_out});
        axi_write(12'h000, 32'hFFFFFFFF, 2'h0);
        axi_read(12'h000, ratio_word(4'h5, 3'h3), 2'h0);
        axi_write(12'hFFC, 32'h1, 2'h3);
        axi_read(12'hFFC, 32'h0, 2'h3);
        axi_write(12'h008, 32'h1, 2'h0);
        pci_addr_core <= 32'hA5A55A5A;
        pci_addr_core_oe <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check("pci oe disabled", 32'h1, {31'h0, pci_addr_oe});
        check("pci addr", 32'hA5A55A5A, pci_addr_out);
        check("flow oe off", 32'h0, {31'h0, eth_flow_oe});
        // por low while frozen must not reach the phase logic
        clk_en <= 1'b0;
        por_n_pin <= 1'b0;
        repeat (8) @(posedge clk_sys);
        check("frozen run", 32'h1, {31'h0, memory_clock_div2});
        clk_en <= 1'b1;
        por_n_pin <= 1'b1;
        arb_internal <= 1'b0;
        repeat (4) @(posedge clk_sys);
        power_up(4'h5, 3'h3);
        check("pci oe ext arb", 32'h0, {31'h0, pci_addr_oe});
        axi_write(12'h008, 32'h0, 2'h0);
        repeat (2) @(posedge clk_sys);
        check("pci oe enabled", 32'h1, {31'h0, pci_addr_oe});
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        $display("ERROR watchdog expected done seen timeout");
        finish_test();
    end
endmodule : reset_strap_clock_ratio_tb
`default_nettype wire

// [tb/strap_board.sv]
// board strap resistors seen by the strap and clock ratio block
`default_nettype none
module strap_board (
    // chosen codes
    input wire logic [3:0] plat_code,
    input wire logic [2:0] core_code,
    input wire logic arb_internal,
    // strap pins
    output logic [3:0] platform_ratio_straps,
    output logic core_ratio_strap_buscontrol,
    output logic core_ratio_strap_addrlatch,
    output logic core_ratio_strap_gpline,
    output logic boot_flash_strap,
    output logic pci_arbiter_strap,
    output logic [1:0] dma_acknowledge_strap,
    output logic [3:0] cfg_spare_straps
);
    timeunit 1ns;
    timeprecision 1ps;
    // every resistor stuffed: no strap relies on the weak pull-up
    assign platform_ratio_straps = plat_code;
    assign {core_ratio_strap_buscontrol, core_ratio_strap_addrlatch,
        core_ratio_strap_gpline} = core_code;
    assign boot_flash_strap = 1'b1;
    // no other agent on the bus, so internal arbiter is safe
    assign pci_arbiter_strap = arb_internal;
    assign dma_acknowledge_strap = 2'b01;
    assign cfg_spare_straps = 4'h0;
    // status pins unloaded; 40 MHz reference needs no separate pci clock
endmodule : strap_board
`default_nettype wire

// [tb/strap_ratio_checker.sv]
// port assertions for the strap and clock ratio block
`default_nettype none
module strap_ratio_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic por_n_pin,
    // straps
    input wire logic [3:0] platform_ratio_straps,
    input wire logic core_ratio_strap_buscontrol,
    input wire logic core_ratio_strap_addrlatch,
    input wire logic core_ratio_strap_gpline,
    // outputs
    input wire logic strap_pullup_en,
    input wire logic [4:0] platform_mult,
    input wire logic [3:0] core_ratio_half,
    input wire logic ratio_valid,
    input wire logic memory_clock_div2,
    input wire logic boot_from_flash,
    input wire logic eth_flow_oe,
    input wire logic reset_request_out,
    input wire logic trigger_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    `include "ratio_ref.svh"
    // ----
    // properties
    // ----
    default clocking cb @(posedge clk_sys);
    endclocking
    // frozen clock enable holds state, so no timing holds then
    default disable iff (!reset_n || !clk_en);
    // por must stay high through the synchroniser before a release counts
    sequence por_up;
        $rose(por_n_pin) ##1 por_n_pin [*3];
    endsequence
    // five edges to reach the reset phase, one more to show it
    sequence por_held;
        (!por_n_pin) [*6];
    endsequence
    chk_pullup_run: assert property (strap_pullup_en == !memory_clock_div2)
        else $error("pull-up enable and run state disagree");
    chk_por_pullup: assert property (por_held |-> strap_pullup_en)
        else $error("pull-up off while power-on reset held");
    chk_reset_drive: assert property (por_held |-> !trigger_ready_out && !reset_request_out)
        else $error("status pins not driven low in reset");
    chk_run_ready: assert property (memory_clock_div2 |-> trigger_ready_out)
        else $error("ready pin low while running");
    chk_por_release: assert property (por_up |-> ##[0:5] memory_clock_div2)
        else $error("no run state after power-on release");
    chk_ratio_hold: assert property (memory_clock_div2 && $past(memory_clock_div2) |->
        $stable(platform_mult) && $stable(core_ratio_half) && $stable(boot_from_flash))
        else $error("latched ratio changed while running");
    chk_plat_decode: assert property ($rose(memory_clock_div2) |->
        platform_mult == plat_ref(platform_ratio_straps))
        else $error("platform multiplier wrong at latch");
    chk_core_decode: assert property ($rose(memory_clock_div2) |-> core_ratio_half ==
        core_ref({core_ratio_strap_buscontrol, core_ratio_strap_addrlatch,
        core_ratio_strap_gpline}))
        else $error("core ratio wrong at latch");
    chk_valid_codes: assert property (ratio_valid == (memory_clock_div2 &&
        platform_mult != 5'h00 && core_ratio_half != 4'h0))
        else $error("ratio valid disagrees with codes");
    chk_eth_fifo: assert property (eth_flow_oe |-> memory_clock_div2)
        else $error("flow pin driven outside run");
endmodule : strap_ratio_checker
bind reset_strap_clock_ratio strap_ratio_checker chk_i (.clk_sys, .reset_n, .clk_en, .por_n_pin,
    .platform_ratio_straps, .core_ratio_strap_buscontrol, .core_ratio_strap_addrlatch,
    .core_ratio_strap_gpline, .strap_pullup_en, .platform_mult, .core_ratio_half,
    .ratio_valid, .memory_clock_div2, .boot_from_flash, .eth_flow_oe, .reset_request_out,
    .trigger_ready_out);
`default_nettype wire
